// ---- design/sio_port.sv ----
// Pin-level command, address and write-data input port, 18-bit mode.
// Assumes all link pins, including both clocks, come from outside the
// core clock domain and are far slower than the 50 MHz core clock.
// Behaviour
// R01 - Capture command inputs on command clock rise
// R02 - Twenty-three address bits give the location
// R03 - Configuration load takes address as settings
// R04 - Three-bit bank select steers every command
// R05 - Decode commands only while select is low
// R06 - Select high never aborts running operations
// R07 - Write data sampled on both strobe edges
// R08 - One strobe clock times all write bits
// R09 - Controller always drives the strobe clock
// R10 - Masked beats are never stored
// R11 - Unmasking controller holds mask low
// R12 - Command formed from write, recharge, select
// R13 - Read halves aligned to separate echo clocks
// R14 - Valid flag edge-aligned to echo clocks
// R15 - Read data follows both echo clock edges
// R16 - Controller drives command clock continuously
module sio_port
    import sio_pkg::*;
#(
    parameter int BEATS = BURST_BEATS
) (
    // Core clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Command clock pair and command pins
    input wire logic i_ck,
    input wire logic i_ck_n,
    input wire logic i_device_select_n,
    input wire logic i_write_cmd_n,
    input wire logic i_recharge_cmd_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [BANK_W-1:0] i_bank,
    // Write strobe clock pair, data and mask
    input wire logic i_write_strobe_clock,
    input wire logic i_write_strobe_clock_n,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_write_byte_mask,
    // Decoded command towards the array
    output logic o_cmd_valid,
    output logic [1:0] o_cmd_kind,
    output logic [ADDR_W-1:0] o_cmd_addr,
    output logic [BANK_W-1:0] o_cmd_bank,
    // Configuration settings
    output logic o_cfg_load,
    output logic [ADDR_W-1:0] o_cfg,
    // Write beats towards the array
    output logic o_wbeat_valid,
    output logic [DATA_W-1:0] o_wbeat_data,
    output logic [7:0] o_wbeat_idx,
    output logic o_wr_busy,
    // Read word from the array, one per echo clock edge
    input wire logic i_rd_valid,
    input wire logic [DATA_W-1:0] i_rd_data,
    // Read pins
    output logic [DATA_W-1:0] o_q,
    output logic [1:0] o_read_echo_clock,
    output logic [1:0] o_read_echo_clock_n,
    output logic o_read_valid_flag
);
    // Elaboration check: the beat index register is eight bits wide
    if (BEATS < 1 || BEATS > 255) $error("sio_port: BEATS must lie in 1..255");
    // Released reset copy used everywhere below
    logic rst_b_q;
    // Asynchronous assert, two-flop release of a constant high
    sio_sync #(.W(1)) u_sync_rst (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(1'b1),
        .o_sync(rst_b_q)
    );
    // Synchronised pin groups
    logic [3:0] clk_s;
    logic [ADDR_W+BANK_W+2:0] cmd_s;
    logic [DATA_W:0] wr_s;
    // Clock pins sampled like any other pin
    sio_sync #(.W(4)) u_sync_clk (
        .i_clk(i_clk),
        .i_rst_b(rst_b_q),
        .i_async({i_ck, i_ck_n, i_write_strobe_clock,
            i_write_strobe_clock_n}),
        .o_sync(clk_s)
    );
    // Command group shares latency with the command clock
    sio_sync #(.W(ADDR_W+BANK_W+3)) u_sync_cmd (
        .i_clk(i_clk),
        .i_rst_b(rst_b_q),
        .i_async({i_device_select_n, i_write_cmd_n, i_recharge_cmd_n,
            i_bank, i_addr}),
        .o_sync(cmd_s)
    );
    // Write group shares latency with the strobe clock
    sio_sync #(.W(DATA_W+1)) u_sync_wr (
        .i_clk(i_clk),
        .i_rst_b(rst_b_q),
        .i_async({i_write_byte_mask, i_wdata}),
        .o_sync(wr_s)
    );
    // Unpacked synchronised fields
    logic ck_s, ck_n_s, dk_s, dk_n_s;
    logic sel_n_s, wr_n_s, rch_n_s, mask_s;
    logic [BANK_W-1:0] bank_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] wdata_s;
    assign {ck_s, ck_n_s, dk_s, dk_n_s} = clk_s;
    assign {sel_n_s, wr_n_s, rch_n_s, bank_s, addr_s} = cmd_s;
    assign {mask_s, wdata_s} = wr_s;
    // Previous clock levels for edge finding
    logic ck_prev_q;
    logic dk_prev_q;
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ck_prev_q <= 1'b0;
            dk_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
            dk_prev_q <= dk_s;
        end
    end
    // Rise of the true phase while the complement sits low
    logic ck_rise;
    logic dk_rise, dk_fall, dk_edge;
    assign ck_rise = ck_s & ~ck_prev_q & ~ck_n_s; // [R01]
    // Both strobe edges, each checked against its complement
    assign dk_rise = dk_s & ~dk_prev_q & ~dk_n_s; // [R07] [R08]
    assign dk_fall = ~dk_s & dk_prev_q & dk_n_s; // [R07] [R08]
    assign dk_edge = dk_rise | dk_fall;
    // A command is decoded only at a rise with select low
    logic cmd_take;
    logic [1:0] cmd_code;
    assign cmd_take = ck_rise & ~sel_n_s; // [R05]
    assign cmd_code = {wr_n_s, rch_n_s}; // [R12]
    // Decoded command register, one-cycle valid pulse
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_cmd_valid <= 1'b0;
            o_cmd_kind <= CMD_READ;
            o_cmd_addr <= '0;
            o_cmd_bank <= '0;
        end else begin
            o_cmd_valid <= cmd_take;
            if (cmd_take) begin
                o_cmd_kind <= cmd_code; // [R12]
                o_cmd_addr <= addr_s; // [R02]
                o_cmd_bank <= bank_s; // [R04]
            end
        end
    end
    // Configuration load takes the address as settings
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_cfg_load <= 1'b0;
            o_cfg <= CFG_RESET;
        end else begin
            o_cfg_load <= cmd_take && cmd_code == CMD_CFG; // [R03]
            if (cmd_take && cmd_code == CMD_CFG) begin
                o_cfg <= addr_s; // [R03]
            end
        end
    end
    // Write capture; the burst ignores select once started
    sio_wstate_e ws_q;
    logic [7:0] beat_q;
    logic wr_start;
    assign wr_start = cmd_take && cmd_code == CMD_WRITE;
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            ws_q <= WS_IDLE;
            beat_q <= 8'h00;
        end else begin
            case (ws_q)
                WS_IDLE: begin
                    if (wr_start) begin
                        ws_q <= WS_BURST;
                        beat_q <= 8'h00;
                    end
                end
                WS_BURST: begin
                    // Select is not looked at here on purpose
                    if (wr_start) begin
                        beat_q <= 8'h00;
                    end else if (dk_edge) begin // [R06]
                        if (beat_q == 8'(BEATS - 1)) begin
                            ws_q <= WS_IDLE;
                        end
                        beat_q <= beat_q + 8'h01;
                    end
                end
                default: begin
                    ws_q <= WS_IDLE;
                end
            endcase
        end
    end
    // Beat output; a masked beat counts but is not passed on
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_wbeat_valid <= 1'b0;
            o_wbeat_data <= '0;
            o_wbeat_idx <= 8'h00;
            o_wr_busy <= 1'b0;
        end else begin
            o_wbeat_valid <= ws_q == WS_BURST && !wr_start && dk_edge &&
                !mask_s; // [R10]
            if (ws_q == WS_BURST && dk_edge) begin
                o_wbeat_data <= wdata_s; // [R07]
                o_wbeat_idx <= beat_q;
            end
            o_wr_busy <= ws_q == WS_BURST;
        end
    end
    // Echo clock divider, free running from reset
    localparam int QK_CW = $clog2(QK_HALF_CYC + 1);
    logic [QK_CW-1:0] qk_cnt_q;
    logic qk_tick;
    assign qk_tick = qk_cnt_q == QK_CW'(QK_HALF_CYC - 1);
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            qk_cnt_q <= '0;
            o_read_echo_clock <= 2'h0;
            o_read_echo_clock_n <= 2'h3;
        end else begin
            qk_cnt_q <= qk_tick ? '0 : qk_cnt_q + 1'b1;
            if (qk_tick) begin
                o_read_echo_clock <= ~o_read_echo_clock; // [R15]
                o_read_echo_clock_n <= ~o_read_echo_clock_n;
            end
        end
    end
    // One read word held until the next echo clock edge
    logic rd_hold_v_q;
    logic [DATA_W-1:0] rd_hold_q;
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            rd_hold_v_q <= 1'b0;
            rd_hold_q <= '0;
        end else begin
            if (i_rd_valid) begin
                rd_hold_v_q <= 1'b1;
                rd_hold_q <= i_rd_data;
            end else if (qk_tick) begin
                rd_hold_v_q <= 1'b0;
            end
        end
    end
    // Pins change only together with the echo clocks
    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            o_q <= '0;
            o_read_valid_flag <= 1'b0;
        end else if (qk_tick) begin
            // Low half on echo pair 0, high half on pair 1
            o_q[HALF_W-1:0] <= rd_hold_q[HALF_W-1:0]; // [R13]
            o_q[DATA_W-1:HALF_W] <= rd_hold_q[DATA_W-1:HALF_W]; // [R13]
            o_read_valid_flag <= rd_hold_v_q; // [R14]
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_b_q);

    a_cmd_on_rise: assert property ( // [R01]
        o_cmd_valid |-> $past(ck_rise))
        else $error("command taken without command clock rise");
    a_sel_blocks: assert property ( // [R05]
        sel_n_s |=> !o_cmd_valid)
        else $error("command decoded while select high");
    a_cmd_fields: assert property ( // [R02]
        cmd_take |=> o_cmd_addr == $past(addr_s) &&
            o_cmd_bank == $past(bank_s))
        else $error("command address or bank not captured");
    a_cmd_kind: assert property ( // [R12]
        cmd_take |=> o_cmd_kind == $past({wr_n_s, rch_n_s}))
        else $error("command kind not formed from pins");
    a_cfg_load: assert property ( // [R03]
        o_cfg_load |-> o_cfg == o_cmd_addr && o_cmd_kind == CMD_CFG)
        else $error("configuration not taken from address");
    a_burst_runs: assert property ( // [R06]
        ws_q == WS_BURST && sel_n_s && !dk_edge |=> ws_q == WS_BURST)
        else $error("burst stopped by select");
    a_mask_drops: assert property ( // [R10]
        ws_q == WS_BURST && dk_edge && mask_s |=> !o_wbeat_valid)
        else $error("masked beat was stored");
    a_beat_data: assert property ( // [R07]
        o_wbeat_valid |-> $past(dk_edge) && o_wbeat_data == $past(wdata_s))
        else $error("write beat not taken on strobe edge");
    a_read_valid_flag_edge: assert property ( // [R14]
        $changed(o_read_valid_flag) |-> $changed(o_read_echo_clock))
        else $error("valid flag moved off echo clock edge");
    a_q_edge: assert property ( // [R15]
        $changed(o_q) |-> $changed(o_read_echo_clock[1]))
        else $error("read data moved off echo clock edge");
    a_qk_pair: assert property ( // [R13]
        o_read_echo_clock[0] == o_read_echo_clock[1] &&
            o_read_echo_clock_n == ~o_read_echo_clock)
        else $error("echo clock pairs not aligned");
endmodule : sio_port

// ---- design/sio_pkg.sv ----
// Shared constants for the separate-I/O DRAM input port.
// Assumes a 50 MHz core clock that oversamples every pin of the link.
package sio_pkg;
    // Core clock period
    localparam int CLK_NS = 20;
    // Bus widths
    localparam int ADDR_W = 23;
    localparam int BANK_W = 3;
    localparam int DATA_W = 18;
    localparam int HALF_W = 9;
    // Write burst length in data beats
    localparam int BURST_BEATS = 2;
    // Half period of the read echo clock, and its cycle count
    localparam int QK_HALF_NS = 40;
    localparam int QK_HALF_CYC = (QK_HALF_NS / CLK_NS < 1) ? 1 :
        QK_HALF_NS / CLK_NS;
    // Command codes formed from {write_cmd_n, recharge_cmd_n}
    localparam logic [1:0] CMD_CFG = 2'h0;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_REFRESH = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    // Reset values
    localparam logic [ADDR_W-1:0] CFG_RESET = 23'h000000;
    // Write capture states
    typedef enum logic [0:0] {
        WS_IDLE = 1'b0,
        WS_BURST = 1'b1
    } sio_wstate_e;
endpackage : sio_pkg

// ---- design/sio_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is stable long enough for one core clock to see it.
module sio_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Pins in, synchronised copy out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    // First stage, read only by the second stage
    logic [W-1:0] meta_q;

    // Two flops in series; constants under reset
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            o_sync <= '0;
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : sio_sync

// ---- test/sio_ctrl_model.sv ----
// Controller model: drives command, address and write pins of the port.
// Assumes the core clock; every pin moves on its falling edge only.
module sio_ctrl_model
    import sio_pkg::*;
(
    // Pacing clock
    input wire logic i_clk,
    // Command clock pair and command pins
    output logic o_ck,
    output logic o_ck_n,
    output logic o_sel_n,
    output logic o_wr_n,
    output logic o_rf_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [BANK_W-1:0] o_bank,
    // Write strobe pair, data and mask
    output logic o_dk,
    output logic o_dk_n,
    output logic [DATA_W-1:0] o_wdata,
    output logic o_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pairs stay complementary by construction
    assign o_ck_n = ~o_ck;
    assign o_dk_n = ~o_dk;
    // Idle levels: strobe parked but driven, mask low
    initial begin
        o_ck = 1'b0;
        o_sel_n = 1'b1;
        o_wr_n = 1'b1;
        o_rf_n = 1'b1;
        o_addr = '0;
        o_bank = '0;
        o_dk = 1'b0;
        o_wdata = '0;
        o_mask = 1'b0;
    end
    // Free-running command clock, 160 ns period
    always begin
        repeat (4) @(negedge i_clk);
        o_ck = ~o_ck;
    end
    // One command per period; pins settle while the clock is low
    task automatic cmd(input logic s, input logic [1:0] k,
            input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
        @(negedge o_ck);
        o_sel_n = s;
        {o_wr_n, o_rf_n} = k;
        o_addr = a;
        o_bank = b;
        @(posedge o_ck);
        repeat (3) @(negedge i_clk);
        // Released select goes high; the other lines never keep the last value
        o_sel_n = 1'b1;
        {o_wr_n, o_rf_n} = ~k;
        o_addr = ~a;
        o_bank = ~b;
    endtask : cmd
    // Two-beat burst; strobe toggles only here, 60 ns each side of edge
    task automatic burst(input logic [DATA_W-1:0] d0, d1,
            input logic [1:0] m);
        for (int i = 0; i < 2; i++) begin
            o_wdata = i ? d1 : d0;
            o_mask = m[i];
            repeat (3) @(negedge i_clk);
            o_dk = ~o_dk;
            repeat (3) @(negedge i_clk);
        end
        o_wdata = ~o_wdata;
        o_mask = 1'b0;
    endtask : burst
endmodule : sio_ctrl_model

// ---- test/sep_io_dram_input_port_tb_top.sv ----
// Self-checking bench for the input port with the controller model.
// Assumes the port's default two-beat burst and a 50 MHz core clock.
module sep_io_dram_input_port_tb_top
    import sio_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ck, i_ck_n, i_device_select_n, i_write_cmd_n, i_recharge_cmd_n;
    logic [ADDR_W-1:0] i_addr, o_cmd_addr, o_cfg;
    logic [BANK_W-1:0] i_bank, o_cmd_bank;
    logic i_write_strobe_clock, i_write_strobe_clock_n, i_write_byte_mask;
    logic [DATA_W-1:0] i_wdata, o_wbeat_data, i_rd_data, o_q;
    logic o_cmd_valid, o_cfg_load, o_wbeat_valid, o_wr_busy;
    logic i_rd_valid, o_read_valid_flag;
    logic [1:0] o_cmd_kind, o_read_echo_clock, o_read_echo_clock_n;
    logic [7:0] o_wbeat_idx;
    int mismatches = 0;
    int checks_done = 0;
    int ncmd = 0; // Decoded command pulses seen
    logic [ADDR_W+BANK_W+1:0] last_cmd; // Kind, address, bank
    logic last_cfg;
    logic [DATA_W+7:0] beats[$]; // Index and data of stored beats
    sio_port sio_port_inst (
        .i_clk, .i_rst_b, .i_ck, .i_ck_n, .i_device_select_n,
        .i_write_cmd_n, .i_recharge_cmd_n, .i_addr, .i_bank,
        .i_write_strobe_clock, .i_write_strobe_clock_n, .i_wdata,
        .i_write_byte_mask, .o_cmd_valid, .o_cmd_kind, .o_cmd_addr,
        .o_cmd_bank, .o_cfg_load, .o_cfg, .o_wbeat_valid, .o_wbeat_data,
        .o_wbeat_idx, .o_wr_busy, .i_rd_valid, .i_rd_data, .o_q,
        .o_read_echo_clock, .o_read_echo_clock_n, .o_read_valid_flag
    );
    sio_ctrl_model sio_ctrl_model_inst (
        .i_clk, .o_ck(i_ck), .o_ck_n(i_ck_n), .o_sel_n(i_device_select_n),
        .o_wr_n(i_write_cmd_n), .o_rf_n(i_recharge_cmd_n), .o_addr(i_addr),
        .o_bank(i_bank), .o_dk(i_write_strobe_clock),
        .o_dk_n(i_write_strobe_clock_n), .o_wdata(i_wdata),
        .o_mask(i_write_byte_mask)
    );
    // 50 MHz core clock
    always #10 i_clk = ~i_clk;
    // Log one-cycle pulses at the falling edge, where outputs are settled
    always @(negedge i_clk) begin
        if (o_cmd_valid === 1'b1) begin
            ncmd++;
            last_cmd = {o_cmd_kind, o_cmd_addr, o_cmd_bank};
            last_cfg = o_cfg_load;
        end
        if (o_wbeat_valid === 1'b1)
            beats.push_back({o_wbeat_idx, o_wbeat_data});
    end
    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t ns: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check
    // Verdict and end of run
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // One command; a deselected one must leave no trace
    task automatic do_cmd(input logic s, input logic [1:0] k,
            input logic [ADDR_W-1:0] a, input logic [BANK_W-1:0] b);
        int n0;
        logic [ADDR_W-1:0] c0;
        n0 = ncmd;
        c0 = o_cfg;
        sio_ctrl_model_inst.cmd(s, k, a, b);
        for (int i = 0; i < 8 && ncmd == n0; i++) @(negedge i_clk);
        if (s) repeat (4) @(negedge i_clk);
        check(ncmd - n0, s ? 0 : 1);
        if (!s) begin
            check(last_cmd, {k, a, b});
            check(last_cfg, k == CMD_CFG);
            check(o_cfg, (k == CMD_CFG) ? a : c0);
        end
    endtask : do_cmd
    // Write command then burst; select is already high during the beats
    task automatic do_write(input logic [ADDR_W-1:0] a,
            input logic [BANK_W-1:0] b, input logic [DATA_W-1:0] d0, d1,
            input logic [1:0] m);
        logic [DATA_W+7:0] exp_b;
        beats.delete();
        do_cmd(1'b0, CMD_WRITE, a, b);
        sio_ctrl_model_inst.burst(d0, d1, m);
        for (int i = 0; i < 8 && o_wr_busy !== 1'b0; i++) @(negedge i_clk);
        check(o_wr_busy, 1'b0);
        check(beats.size(), 2 - m[0] - m[1]);
        for (int i = 0; i < 2; i++) begin
            exp_b = {8'(i), i ? d1 : d0};
            if (!m[i] && beats.size() > 0)
                check(beats.pop_front(), exp_b);
        end
    endtask : do_write
    // Read word appears with the next echo toggle, flag drops after
    task automatic do_read(input logic [DATA_W-1:0] d);
        logic e;
        logic [3:0] qk_exp;
        i_rd_valid = 1'b1;
        i_rd_data = d;
        @(negedge i_clk);
        i_rd_valid = 1'b0;
        i_rd_data = ~d;
        // Word is held now; a toggle in the take cycle still showed old data
        e = o_read_echo_clock[0];
        qk_exp = {~e, ~e, e, e};
        for (int i = 0; i < 4 && o_read_echo_clock[0] === e; i++)
            @(negedge i_clk);
        check(o_q, d);
        check(o_read_valid_flag, 1'b1);
        check({o_read_echo_clock, o_read_echo_clock_n}, qk_exp);
        for (int i = 0; i < 4 && o_read_echo_clock[0] !== e; i++)
            @(negedge i_clk);
        check(o_read_valid_flag, 1'b0);
    endtask : do_read
    // Main sequence: corners first, then random traffic
    initial begin
        logic s;
        logic [1:0] k;
        logic [ADDR_W-1:0] a;
        void'($urandom(49630));
        i_rd_valid = 1'b0;
        i_rd_data = '0;
        repeat (4) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (6) @(negedge i_clk);
        do_cmd(1'b0, CMD_CFG, 23'h7FFFFF, 3'h7);
        do_cmd(1'b1, CMD_CFG, 23'h000000, 3'h0);
        for (int i = 0; i < 4; i++)
            do_cmd(1'b0, 2'(i), ADDR_W'($urandom), 3'(i));
        for (int i = 0; i < 4; i++)
            do_write(23'h0, 3'h5, 18'h3FFFF, 18'h15A5A, 2'(i));
        repeat (12) begin
            s = ($urandom % 4) == 0;
            k = 2'($urandom);
            a = ADDR_W'($urandom);
            if (k == CMD_WRITE && !s)
                do_write(a, 3'($urandom), DATA_W'($urandom),
                    DATA_W'($urandom), 2'($urandom));
            else
                do_cmd(s, k, a, 3'($urandom));
        end
        do_read(18'h3FFFF);
        do_read(18'h00000);
        repeat (4) do_read(DATA_W'($urandom));
        test_done;
    end
    // Watchdog far beyond the expected run of some 8 us
    initial begin
        #100us;
        mismatches++;
        test_done;
    end
endmodule : sep_io_dram_input_port_tb_top
